// ### ufd_pkg.sv
// Package with register map, field layout and queue and teardown types of the USB FIFO and packet DMA channel registers.
package ufd_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_TX_CH = 4;
   localparam int NUM_EP = 4;
   // Register byte offsets; nothing prints them, so they are chosen here.
   localparam logic [7:0] OFS_TX_FIFO_START   = 8'h00;
   localparam logic [7:0] OFS_RX_FIFO_START   = 8'h10;
   localparam logic [7:0] OFS_HW_VERSION      = 8'h20;
   localparam logic [7:0] OFS_DMA_REV_LOW     = 8'h24;
   localparam logic [7:0] OFS_DMA_REV_HIGH    = 8'h28;
   localparam logic [7:0] OFS_TEARDOWN_QUEUE  = 8'h2C;
   localparam logic [7:0] OFS_DMA_EMULATION   = 8'h30;
   localparam logic [7:0] OFS_IRQ_STATUS      = 8'h34;
   localparam logic [7:0] OFS_IRQ_MASK        = 8'h38;
   localparam logic [7:0] OFS_TX_RETURN_QUEUE = 8'h40;
   localparam logic [7:0] OFS_TX_CONTROL      = 8'h50;
   // Field positions.
   localparam int FIFO_ADDR_MSB  = 12;
   localparam int FIFO_UNIT_LOG2 = 3;
   localparam int VER_RC_BIT     = 15;
   localparam int VER_MAJ_MSB    = 14;
   localparam int VER_MAJ_LSB    = 10;
   localparam int VER_MIN_MSB    = 9;
   localparam int QMGR_MSB       = 13;
   localparam int QMGR_LSB       = 12;
   localparam int QNUM_MSB       = 11;
   localparam int EMU_SOFT_BIT   = 1;
   localparam int EMU_FREE_BIT   = 0;
   localparam int TX_ENABLE_BIT  = 15;
   localparam int TX_TEARDOWN_BIT = 14;
   // Reset values.
   localparam logic [15:0] RST_FIFO_START = 16'h0000;
   localparam logic [15:0] RST_QUEUE      = 16'h0000;
   localparam logic [1:0]  RST_EMULATION  = 2'h0;
   localparam logic [15:0] RST_CONTROL    = 16'h0000;
   localparam logic [15:0] EP0_FIFO_BYTES = 16'h0040;
   localparam logic [15:0] MINOR_MAX      = 16'h03E7;
   typedef struct packed {
      logic [1:0]  qmgr;
      logic [11:0] qnum;
   } ufd_queue_s;
   typedef struct packed {
      logic [1:0]  channel;
      ufd_queue_s  source;
      ufd_queue_s  target;
   } ufd_teardown_s;
endpackage : ufd_pkg

// ### ufd_regs.sv
// Register bank for endpoint FIFO placement, version, packet DMA revision, emulation and transmit channel control.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Operation
// - FIFO start field bits 12:0; byte address is eight times the value.
// - Version bit 15 flags release candidate; bits 14:10 hold major version.
// - Version bits 9:0 hold minor version, decimal 0 to 999.
// - DMA revision split over two read-only halves: low then high.
// - Teardown queue bits 13:12 pick one of four queue managers.
// - Teardown queue bits 11:0 pick one of 4K queues.
// - Teardown completion of every channel uses descriptors from that queue.
// - Four transmit channels, each with a pair of configuration registers.
// - Per channel, bits 13:12 and 11:0 select the teardown return queue.
// - Channel enable bit 15; hardware clears it when teardown completes.
// - Writing one to bit 14 requests teardown; the bit stays set afterwards.
// - Emulation control has soft-stop bit 1 and free-run bit 0.
// - Endpoint 0 FIFO is fixed: 64 bytes at address zero.
module ufd_regs #(
   parameter logic        VER_RC     = 1'b0,
   parameter logic [4:0]  VER_MAJOR  = 5'h01,
   parameter logic [9:0]  VER_MINOR  = 10'h000,
   // Revision value is arbitrary.
   parameter logic [31:0] DMA_REV_ID = 32'h0001_0000
) (
   input  wire logic                    clock_i,
   input  wire logic                    rst_i,
   input  wire logic [7:0]              addr_i,
   input  wire logic [15:0]             wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic [15:0]                  rdata_o,
   input  wire logic                    td_done_i,
   input  wire logic [1:0]              td_done_ch_i,
   output logic                         td_move_o,
   output ufd_pkg::ufd_teardown_s       td_move_o_info,
   output logic [3:0]                   tx_enable_o,
   output logic [3:0]                   tx_teardown_req_o,
   output logic [15:0]                  tx_fifo_byte_addr_o [4],
   output logic [15:0]                  rx_fifo_byte_addr_o [4],
   output logic                         emu_soft_o,
   output logic                         emu_free_o,
   output logic                         irq_o
);
   // The minor version field holds a decimal count, so anything above 999 cannot be reported.
   if (VER_MINOR > ufd_pkg::MINOR_MAX[9:0]) begin : g_minor_check
      $error("minor version above 999");
   end

   logic [12:0] tx_fifo_q [4];
   logic [12:0] rx_fifo_q [4];
   ufd_pkg::ufd_queue_s td_queue_q;
   ufd_pkg::ufd_queue_s ret_q [4];
   logic [3:0]  en_q;
   logic [3:0]  tdreq_q;
   logic [1:0]  emu_q;
   logic [3:0]  irq_stat_q;
   logic [3:0]  irq_mask_q;
   logic [15:0] rdata_q;

   // Endpoint 0 keeps its array slot, but its outputs skip this and stay fixed at address zero.
   function automatic logic [15:0] fifo_byte(input logic [12:0] f);
      return {f, 3'b000};
   endfunction : fifo_byte

   wire [1:0]  idx       = addr_i[3:2];
   wire        sel_txf   = (addr_i[7:4] == ufd_pkg::OFS_TX_FIFO_START[7:4]);
   wire        sel_rxf   = (addr_i[7:4] == ufd_pkg::OFS_RX_FIFO_START[7:4]);
   wire        sel_ret   = (addr_i[7:4] == ufd_pkg::OFS_TX_RETURN_QUEUE[7:4]);
   wire        sel_ctl   = (addr_i[7:4] == ufd_pkg::OFS_TX_CONTROL[7:4]);
   wire        aligned   = (addr_i[1:0] == 2'b00);
   wire        wr_tdq    = wr_i && addr_i == ufd_pkg::OFS_TEARDOWN_QUEUE;
   wire        wr_emu    = wr_i && addr_i == ufd_pkg::OFS_DMA_EMULATION;
   wire        wr_msk    = wr_i && addr_i == ufd_pkg::OFS_IRQ_MASK;
   wire        rd_stat   = rd_i && addr_i == ufd_pkg::OFS_IRQ_STATUS;
   wire        wr_ctl    = wr_i && sel_ctl && aligned;
   wire [3:0]  done_vec  = td_done_i ? (4'h1 << td_done_ch_i) : 4'h0;
   wire [15:0] ver_word  = {VER_RC, VER_MAJOR, VER_MINOR};

   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      if (aligned) begin
         if (sel_txf) rd_mux = {3'b000, tx_fifo_q[idx]};
         else if (sel_rxf) rd_mux = {3'b000, rx_fifo_q[idx]};
         else if (sel_ret) rd_mux = {2'b00, ret_q[idx]};
         else if (sel_ctl) rd_mux = {en_q[idx], tdreq_q[idx], 14'h0000};
         else begin
            unique case (addr_i)
               ufd_pkg::OFS_HW_VERSION:     rd_mux = ver_word;
               ufd_pkg::OFS_DMA_REV_LOW:    rd_mux = DMA_REV_ID[15:0];
               ufd_pkg::OFS_DMA_REV_HIGH:   rd_mux = DMA_REV_ID[31:16];
               ufd_pkg::OFS_TEARDOWN_QUEUE: rd_mux = {2'b00, td_queue_q};
               ufd_pkg::OFS_DMA_EMULATION:  rd_mux = {14'h0000, emu_q};
               ufd_pkg::OFS_IRQ_STATUS:     rd_mux = {12'h000, irq_stat_q};
               ufd_pkg::OFS_IRQ_MASK:       rd_mux = {12'h000, irq_mask_q};
               default:                     rd_mux = 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            tx_fifo_q[i] <= ufd_pkg::RST_FIFO_START[12:0];
            rx_fifo_q[i] <= ufd_pkg::RST_FIFO_START[12:0];
            ret_q[i]     <= ufd_pkg::RST_QUEUE[13:0];
         end
         td_queue_q <= ufd_pkg::RST_QUEUE[13:0];
         emu_q      <= ufd_pkg::RST_EMULATION;
         irq_mask_q <= 4'h0;
         rdata_q    <= 16'h0000;
      end else begin
         rdata_q <= rd_i ? rd_mux : 16'h0000;
         if (wr_i && aligned && sel_txf) tx_fifo_q[idx] <= wdata_i[12:0];
         if (wr_i && aligned && sel_rxf) rx_fifo_q[idx] <= wdata_i[12:0];
         if (wr_i && aligned && sel_ret) ret_q[idx] <= wdata_i[13:0];
         if (wr_tdq) td_queue_q <= wdata_i[13:0];
         if (wr_emu) emu_q <= wdata_i[1:0];
         if (wr_msk) irq_mask_q <= wdata_i[3:0];
      end
   end

   // Channel control: completion on an enabled channel clears enable in the same cycle a write could set it; completion wins
   // because the channel has already been torn down and must be re-armed deliberately.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         en_q       <= 4'h0;
         tdreq_q    <= 4'h0;
         irq_stat_q <= 4'h0;
      end else begin
         for (int c = 0; c < ufd_pkg::NUM_TX_CH; c++) begin
            if (wr_ctl && idx == c[1:0]) begin
               en_q[c]    <= wdata_i[ufd_pkg::TX_ENABLE_BIT];
               tdreq_q[c] <= wdata_i[ufd_pkg::TX_TEARDOWN_BIT];
            end
            if (done_vec[c] && en_q[c]) en_q[c] <= 1'b0;
         end
         // Status is sticky; a new completion wins over the read that clears it.
         irq_stat_q <= (rd_stat ? 4'h0 : irq_stat_q) | (done_vec & en_q);
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         td_move_o      <= 1'b0;
         td_move_o_info <= '0;
         irq_o          <= 1'b0;
         emu_soft_o     <= 1'b0;
         emu_free_o     <= 1'b0;
         tx_enable_o    <= 4'h0;
         tx_teardown_req_o <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            tx_fifo_byte_addr_o[i] <= 16'h0000;
            rx_fifo_byte_addr_o[i] <= 16'h0000;
         end
      end else begin
         td_move_o      <= done_vec != 4'h0 && en_q[td_done_ch_i];
         td_move_o_info <= {td_done_ch_i, td_queue_q, ret_q[td_done_ch_i]};
         irq_o          <= |((irq_stat_q | (done_vec & en_q)) & irq_mask_q & ~(rd_stat ? irq_stat_q : 4'h0));
         emu_soft_o     <= emu_q[ufd_pkg::EMU_SOFT_BIT];
         emu_free_o     <= emu_q[ufd_pkg::EMU_FREE_BIT];
         tx_enable_o    <= en_q;
         tx_teardown_req_o <= tdreq_q;
         for (int i = 0; i < 4; i++) begin
            // Slot 0 describes endpoint 0 and is pinned to zero.
            tx_fifo_byte_addr_o[i] <= (i == 0) ? 16'h0000 : fifo_byte(tx_fifo_q[i]);
            rx_fifo_byte_addr_o[i] <= (i == 0) ? 16'h0000 : fifo_byte(rx_fifo_q[i]);
         end
      end
   end

   assign rdata_o = rdata_q;

   AST_TD_CLEARS_EN: assert property (@(posedge clock_i) disable iff (rst_i)
      td_done_i && en_q[td_done_ch_i] && !wr_ctl |=> !en_q[$past(td_done_ch_i)]) else $error("enable not cleared");
   AST_TD_MOVE: assert property (@(posedge clock_i) disable iff (rst_i)
      td_done_i && en_q[td_done_ch_i] |=> td_move_o && td_move_o_info.source == $past(td_queue_q))
      else $error("teardown move missing");
   AST_TDREQ_STAYS: assert property (@(posedge clock_i) disable iff (rst_i)
      tdreq_q[0] && !(wr_ctl && idx == 2'd0) |=> tdreq_q[0]) else $error("teardown bit lost");
   AST_RSVD_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
      rd_i && sel_ctl |=> rdata_o[13:0] == 14'h0000) else $error("reserved bits nonzero");
   AST_VER_READ: assert property (@(posedge clock_i) disable iff (rst_i)
      rd_i && addr_i == ufd_pkg::OFS_HW_VERSION |=> rdata_o[9:0] <= 10'd999 && rdata_o[15] == VER_RC)
      else $error("version read wrong");
   AST_REV_HIGH: assert property (@(posedge clock_i) disable iff (rst_i)
      rd_i && addr_i == ufd_pkg::OFS_DMA_REV_HIGH |=> rdata_o == DMA_REV_ID[31:16]) else $error("revision high");
   AST_FIFO_SCALE: assert property (@(posedge clock_i) disable iff (rst_i)
      1'b1 |=> tx_fifo_byte_addr_o[1] == {$past(tx_fifo_q[1]), 3'b000}) else $error("fifo scale wrong");
   AST_EP0_FIXED: assert property (@(posedge clock_i) disable iff (rst_i)
      rx_fifo_byte_addr_o[0] == 16'h0000 && tx_fifo_byte_addr_o[0] == 16'h0000) else $error("ep0 moved");
   AST_EMU_BITS: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_emu |=> ##1 emu_soft_o == $past(wdata_i[1], 2)) else $error("soft bit");
endmodule : ufd_regs

// ### ufd_regs_tb.sv
// Self-checking testbench for the USB FIFO and packet DMA channel register bank.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
   $display("mismatch %s expected %h seen %h", nm, ex, got); bad_count++; end end
module ufd_regs_tb;
   localparam logic        T_RC  = 1'b1;
   localparam logic [4:0]  T_MAJ = 5'h1F;
   localparam logic [9:0]  T_MIN = 10'h3E7;
   // Revision value is arbitrary.
   localparam logic [31:0] T_REV = 32'h1234_5678;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        td_done_i = 1'b0;
   logic [1:0]  td_done_ch_i = 2'h0;
   logic [15:0] rdata_o;
   logic        td_move_o;
   ufd_pkg::ufd_teardown_s td_move_o_info;
   logic [3:0]  tx_enable_o;
   logic [3:0]  tx_teardown_req_o;
   logic [15:0] tx_fifo_byte_addr_o [4];
   logic [15:0] rx_fifo_byte_addr_o [4];
   logic        emu_soft_o;
   logic        emu_free_o;
   logic        irq_o;
   int          bad_count = 0;
   int          n_checks = 0;
   int          seed;
   logic [15:0] v, tq, rq;
   ufd_regs #(.VER_RC(T_RC), .VER_MAJOR(T_MAJ), .VER_MINOR(T_MIN), .DMA_REV_ID(T_REV)) i_ufd_regs (
      .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .td_done_i(td_done_i), .td_done_ch_i(td_done_ch_i), .td_move_o(td_move_o),
      .td_move_o_info(td_move_o_info), .tx_enable_o(tx_enable_o), .tx_teardown_req_o(tx_teardown_req_o),
      .tx_fifo_byte_addr_o(tx_fifo_byte_addr_o), .rx_fifo_byte_addr_o(rx_fifo_byte_addr_o),
      .emu_soft_o(emu_soft_o), .emu_free_o(emu_free_o), .irq_o(irq_o));
   always #2.5 clock_i = ~clock_i;
   function automatic logic [7:0] ofs(input logic [7:0] base, input int n);
      return base + 8'(4 * n);
   endfunction : ofs
   // Endpoint 0 never moves, whatever its slot holds.
   function automatic logic [15:0] exp_byte_addr(input int ep, input logic [15:0] f);
      return (ep == 0) ? 16'h0000 : {f[12:0], 3'b000};
   endfunction : exp_byte_addr
   task automatic report_and_stop;
      if (bad_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 `CHK($sformatf("reg %h", a), e, rdata_o)
   endtask : rchk
   // Pulses teardown done and watches a short window for the descriptor move.
   task automatic td(input logic [1:0] ch, input logic exp_move, input logic [15:0] q, input logic [15:0] r);
      logic seen;
      @(posedge clock_i);
      td_done_i <= 1'b1; td_done_ch_i <= ch;
      @(posedge clock_i);
      td_done_i <= 1'b0;
      seen = 1'b0;
      for (int k = 0; k < 3; k++) begin
         #1 if (td_move_o === 1'b1 && !seen) begin
            seen = 1'b1;
            `CHK("move info", {ch, q[13:0], r[13:0]}, td_move_o_info)
         end
         @(posedge clock_i);
      end
      `CHK("td_move_o", exp_move, seen)
   endtask : td
   initial begin
      repeat (20000) @(posedge clock_i);
      bad_count++;
      report_and_stop();
   end
   initial begin
      seed = 32'hfecf;
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      rchk(ufd_pkg::OFS_HW_VERSION, {T_RC, T_MAJ, T_MIN});
      rchk(ufd_pkg::OFS_DMA_REV_LOW, T_REV[15:0]);
      rchk(ufd_pkg::OFS_DMA_REV_HIGH, T_REV[31:16]);
      rchk(ufd_pkg::OFS_TEARDOWN_QUEUE, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         rchk(ofs(ufd_pkg::OFS_TX_CONTROL, i), 16'h0000);
         v = (i == 3) ? 16'hFFFF : 16'($random(seed));
         wr(ofs(ufd_pkg::OFS_TX_FIFO_START, i), v);
         wr(ofs(ufd_pkg::OFS_RX_FIFO_START, i), ~v);
         rchk(ofs(ufd_pkg::OFS_TX_FIFO_START, i), v & 16'h1FFF);
         rchk(ofs(ufd_pkg::OFS_RX_FIFO_START, i), ~v & 16'h1FFF);
         repeat (2) @(posedge clock_i);
         #1 `CHK("tx byte addr", exp_byte_addr(i, v), tx_fifo_byte_addr_o[i])
         `CHK("rx byte addr", exp_byte_addr(i, ~v), rx_fifo_byte_addr_o[i])
      end
      tq = 16'($random(seed));
      wr(ufd_pkg::OFS_TEARDOWN_QUEUE, tq);
      rchk(ufd_pkg::OFS_TEARDOWN_QUEUE, tq & 16'h3FFF);
      for (int e = 0; e < 4; e++) begin
         wr(ufd_pkg::OFS_DMA_EMULATION, {14'($random(seed)), 2'(e)});
         rchk(ufd_pkg::OFS_DMA_EMULATION, 16'(e));
         #1 `CHK("emulation", 2'(e), {emu_soft_o, emu_free_o})
      end
      wr(8'h3C, 16'hFFFF);
      rchk(8'h3C, 16'h0000);
      rchk(8'h22, 16'h0000);
      wr(ufd_pkg::OFS_IRQ_MASK, 16'h0007);
      rchk(ufd_pkg::OFS_IRQ_MASK, 16'h0007);
      for (int ch = 0; ch < 4; ch++) begin
         rq = 16'($random(seed));
         wr(ofs(ufd_pkg::OFS_TX_RETURN_QUEUE, ch), rq);
         rchk(ofs(ufd_pkg::OFS_TX_RETURN_QUEUE, ch), rq & 16'h3FFF);
         wr(ofs(ufd_pkg::OFS_TX_CONTROL, ch), 16'hC000 | (rq & 16'h3FFF));
         rchk(ofs(ufd_pkg::OFS_TX_CONTROL, ch), 16'hC000);
         #1 `CHK("channel bits", 2'b11, {tx_enable_o[ch], tx_teardown_req_o[ch]})
         td(2'(ch), 1'b1, tq, rq);
         rchk(ofs(ufd_pkg::OFS_TX_CONTROL, ch), 16'h4000);
         `CHK("irq_o", (ch != 3), irq_o)
         rchk(ufd_pkg::OFS_IRQ_STATUS, 16'(1 << ch));
         rchk(ufd_pkg::OFS_IRQ_STATUS, 16'h0000);
         repeat (2) @(posedge clock_i);
         #1 `CHK("irq_o cleared", 1'b0, irq_o)
         // A disabled channel has nothing to tear down, so no descriptor moves.
         td(2'(ch), 1'b0, tq, rq);
      end
      report_and_stop();
   end
endmodule : ufd_regs_tb
